/* File: rtl/hss_top.sv */
// hub strap sampling, suspend indicator and axi4-lite status registers
// assumes all pins are synchronous to aclk; the pad ring resolves the
// shared indicator pin from led_pin_out and led_pin_oe_n
//
// Functional notes
// - the upper method-select strap is captured when the hub reset input rises.
// - on the small package the upper method-select bit is always zero.
// - with the reset input tied high, reset lasts until the supplies are stable.
// - the suspend indicator is asserted only while configured and not suspended.
// - fixed-port code 00 none, 01 port 1, 10 ports 1-2, 11 ports 1-3.
// - the indicator is active high for codes 00 and 10, active low for 01 and 11.
// - an external clock runs 24 MHz mode with rate select 0, 48 MHz mode with 1.
// - the 48 MHz external clock option exists only on the large package.
// - a pulled-down test input enables an xnor continuity check over the pins.
// - the two lower method-select straps are captured the same way.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hss_cfg.svh"

module hss_top
  import hss_pkg::*;
#(
  parameter bit PKG_LARGE = 1'b1
)
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               aclken,
  input  wire hss_pkg::hss_axi_req_t axi_req,
  output hss_pkg::hss_axi_rsp_t   axi_rsp,
  input  wire logic               hub_reset_n,
  input  wire logic               supply_stable,
  input  wire logic               config_method_select_b2,
  input  wire logic               config_method_select_b1,
  input  wire logic               config_method_select_b0,
  input  wire logic               fixed_port_strap_hi,
  input  wire logic               ext_clock_rate_select,
  input  wire logic               oscillator_external,
  input  wire logic               test_enable,
  input  wire logic               led_pin_in,
  output logic                    led_pin_out,
  output logic                    led_pin_oe_n,
  output logic                    hub_in_reset,
  output logic [2:0]              fixed_port_mask,
  output logic [1:0]              config_method,
  output logic                    self_powered,
  output logic                    clk48_mode,
  output logic                    continuity_out
);

  // ****************************************
  // internal hub reset
  // ****************************************
  // por stands in for the pin when it is tied high
  wire logic hub_run;
  assign hub_run = hub_reset_n & supply_stable;

  hss_strap_t straps;

  hss_strap_latch #(
    .PKG_LARGE    (PKG_LARGE)
  ) u_latch (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .aclken       (aclken),
    .hub_run      (hub_run),
    .sel_b2       (config_method_select_b2),
    .sel_b1       (config_method_select_b1),
    .sel_b0       (config_method_select_b0),
    .fix_hi       (fixed_port_strap_hi),
    .fix_lo       (led_pin_in),
    .rate_sel     (ext_clock_rate_select),
    .osc_external (oscillator_external),
    .straps       (straps)
  );

  // ****************************************
  // register state
  // ****************************************
  logic [`HSS_CTRL_W-1:0]  ctrl_ff;
  logic                    awready_ff;
  logic                    wready_ff;
  logic                    bvalid_ff;
  logic [1:0]              bresp_ff;
  logic                    arready_ff;
  logic                    rvalid_ff;
  logic [`HSS_DATA_W-1:0]  rdata_ff;
  logic [1:0]              rresp_ff;
  logic                    aw_got_ff;
  logic                    w_got_ff;
  logic [`HSS_ADDR_W-1:0]  awaddr_ff;
  logic [`HSS_DATA_W-1:0]  wdata_ff;
  logic [3:0]              wstrb_ff;

  logic                    led_out_ff;
  logic                    led_oe_n_ff;
  logic                    in_reset_ff;
  logic [2:0]              fix_mask_ff;
  logic [1:0]              method_ff;
  logic                    self_pwr_ff;
  logic                    clk48_ff;
  logic                    cont_ff;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic known_addr(input logic [`HSS_ADDR_W-1:0] a);
    return (a == `HSS_CTRL_ADDR) || (a == `HSS_STAT_ADDR);
  endfunction

  wire logic aw_hs;
  wire logic w_hs;
  wire logic b_hs;
  wire logic ar_hs;
  wire logic r_hs;
  wire logic do_wr;
  wire logic wr_ctrl;
  wire logic nxt_aw_got;
  wire logic nxt_w_got;
  wire logic nxt_bvalid;
  wire logic nxt_rvalid;
  wire logic [1:0] nxt_bresp;
  wire logic [1:0] nxt_rresp;
  wire logic [`HSS_CTRL_W-1:0] nxt_ctrl;

  assign aw_hs = axi_req.awvalid & awready_ff;
  assign w_hs  = axi_req.wvalid & wready_ff;
  assign b_hs  = bvalid_ff & axi_req.bready;
  assign ar_hs = axi_req.arvalid & arready_ff;
  assign r_hs  = rvalid_ff & axi_req.rready;

  // address and data may arrive in either order; commit once both held
  assign do_wr      = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign wr_ctrl    = do_wr & (awaddr_ff == `HSS_CTRL_ADDR) & wstrb_ff[0];
  assign nxt_aw_got = do_wr ? 1'b0 : (aw_got_ff | aw_hs);
  assign nxt_w_got  = do_wr ? 1'b0 : (w_got_ff | w_hs);
  assign nxt_bvalid = do_wr | (bvalid_ff & ~b_hs);
  assign nxt_rvalid = ar_hs | (rvalid_ff & ~r_hs);
  assign nxt_bresp  = known_addr(awaddr_ff) ? `HSS_RESP_OKAY : `HSS_RESP_SLVERR;
  assign nxt_rresp  = known_addr(axi_req.araddr) ? `HSS_RESP_OKAY : `HSS_RESP_SLVERR;
  // status is read-only; writes to it answer okay and change nothing
  assign nxt_ctrl   = wr_ctrl ? wdata_ff[`HSS_CTRL_W-1:0] : ctrl_ff;

  // ****************************************
  // status word
  // ****************************************
  wire logic [`HSS_DATA_W-1:0] status_word;
  wire logic [`HSS_DATA_W-1:0] nxt_rdata;

  assign status_word = {
    17'h0_0000,
    led_out_ff,
    test_enable,
    in_reset_ff,
    straps.strap_en,
    straps.clk48,
    straps.self_pwr,
    straps.led_low,
    straps.fixed_mask,
    straps.method,
    straps.sel
  };

  assign nxt_rdata =
    (axi_req.araddr == `HSS_CTRL_ADDR) ? {30'h0000_0000, ctrl_ff} :
    (axi_req.araddr == `HSS_STAT_ADDR) ? status_word :
                                         32'h0000_0000;

  // ****************************************
  // axi write channel
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `HSS_RESP_OKAY;
      ctrl_ff    <= `HSS_CTRL_RST;
    end
    else if (aclken)
    begin
      if (aw_hs)
      begin
        awaddr_ff <= axi_req.awaddr;
      end
      if (w_hs)
      begin
        wdata_ff <= axi_req.wdata;
        wstrb_ff <= axi_req.wstrb;
      end
      if (do_wr)
      begin
        bresp_ff <= nxt_bresp;
      end
      aw_got_ff  <= nxt_aw_got;
      w_got_ff   <= nxt_w_got;
      bvalid_ff  <= nxt_bvalid;
      awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_got & ~nxt_bvalid;
      ctrl_ff    <= nxt_ctrl;
    end
  end

  // ****************************************
  // axi read channel
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= `HSS_RESP_OKAY;
    end
    else if (aclken)
    begin
      if (ar_hs)
      begin
        rdata_ff <= nxt_rdata;
        rresp_ff <= nxt_rresp;
      end
      rvalid_ff  <= nxt_rvalid;
      arready_ff <= ~nxt_rvalid;
    end
  end

  assign axi_rsp = '{
    awready : awready_ff,
    wready  : wready_ff,
    bvalid  : bvalid_ff,
    bresp   : bresp_ff,
    arready : arready_ff,
    rvalid  : rvalid_ff,
    rdata   : rdata_ff,
    rresp   : rresp_ff
  };

  // ****************************************
  // indicator pin and continuity
  // ****************************************
  wire logic led_asserted;
  wire logic nxt_led_out;
  wire logic nxt_cont;

  assign led_asserted = ctrl_ff[`HSS_CTRL_CONF_BIT] &
                        ~ctrl_ff[`HSS_CTRL_SUSP_BIT];
  assign nxt_led_out  = led_asserted ^ straps.led_low;
  // pull-down keeps the check off when the test input floats
  assign nxt_cont     = test_enable &
                        ~^{config_method_select_b2, config_method_select_b1,
                           config_method_select_b0, fixed_port_strap_hi,
                           ext_clock_rate_select, hub_reset_n,
                           led_pin_in};

  // pin floats while in reset so its strap level can be sampled;
  // relies on the source holding reset low for well over a cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      led_out_ff  <= 1'b0;
      led_oe_n_ff <= 1'b1;
      in_reset_ff <= 1'b1;
      fix_mask_ff <= 3'h0;
      method_ff   <= 2'h0;
      self_pwr_ff <= 1'b0;
      clk48_ff    <= 1'b0;
      cont_ff     <= 1'b0;
    end
    else if (aclken)
    begin
      led_out_ff  <= nxt_led_out;
      led_oe_n_ff <= ~(hub_run & ~in_reset_ff);
      in_reset_ff <= ~hub_run;
      fix_mask_ff <= straps.fixed_mask;
      method_ff   <= straps.method;
      self_pwr_ff <= straps.self_pwr;
      clk48_ff    <= straps.clk48;
      cont_ff     <= nxt_cont;
    end
  end

  assign led_pin_out     = led_out_ff;
  assign led_pin_oe_n    = led_oe_n_ff;
  assign hub_in_reset    = in_reset_ff;
  assign fixed_port_mask = fix_mask_ff;
  assign config_method   = method_ff;
  assign self_powered    = self_pwr_ff;
  assign clk48_mode      = clk48_ff;
  assign continuity_out  = cont_ff;

endmodule
`default_nettype wire

/* File: rtl/hss_cfg.svh */
// constants for the hub strap sampling and status block
// assumes a 32-bit axi4-lite register bus and a 40 MHz aclk
`ifndef HSS_CFG_SVH
`define HSS_CFG_SVH

// ****************************************
// bus shape
// ****************************************
`define HSS_ADDR_W        8
`define HSS_DATA_W        32

// ****************************************
// register byte offsets
// ****************************************
`define HSS_CTRL_ADDR     8'h00
`define HSS_STAT_ADDR     8'h04

// ****************************************
// control fields and reset value
// ****************************************
`define HSS_CTRL_CONF_BIT 0
`define HSS_CTRL_SUSP_BIT 1
`define HSS_CTRL_W        2
`define HSS_CTRL_RST      2'h0

// ****************************************
// status fields
// ****************************************
`define HSS_ST_SEL_LSB    0
`define HSS_ST_METH_LSB   3
`define HSS_ST_FIX_LSB    5
`define HSS_ST_POL_BIT    8
`define HSS_ST_PWR_BIT    9
`define HSS_ST_C48_BIT    10
`define HSS_ST_SEN_BIT    11
`define HSS_ST_RST_BIT    12
`define HSS_ST_TST_BIT    13
`define HSS_ST_LED_BIT    14

// ****************************************
// response codes and timing
// ****************************************
`define HSS_RESP_OKAY     2'h0
`define HSS_RESP_SLVERR   2'h2
`define HSS_CLK_HZ        40000000
`define HSS_RST_MIN_NS    1000
`define HSS_RST_MIN_CYC   ((`HSS_RST_MIN_NS * (`HSS_CLK_HZ / 1000000) + 999) / 1000)

`endif

/* File: rtl/hss_pkg.sv */
// types shared by the strap sampling block and its bench
// assumes hss_cfg.svh is on the include path
`include "hss_cfg.svh"

package hss_pkg;

  typedef struct packed {
    logic                    awvalid;
    logic [`HSS_ADDR_W-1:0]  awaddr;
    logic                    wvalid;
    logic [`HSS_DATA_W-1:0]  wdata;
    logic [3:0]              wstrb;
    logic                    bready;
    logic                    arvalid;
    logic [`HSS_ADDR_W-1:0]  araddr;
    logic                    rready;
  } hss_axi_req_t;

  typedef struct packed {
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [`HSS_DATA_W-1:0]  rdata;
    logic [1:0]              rresp;
  } hss_axi_rsp_t;

  typedef enum logic [1:0] {
    HSS_METH_DEFAULT = 2'b00,
    HSS_METH_SMBUS   = 2'b01,
    HSS_METH_EEPROM  = 2'b10
  } hss_method_t;

  typedef struct packed {
    logic [2:0]   sel;
    hss_method_t  method;
    logic         strap_en;
    logic [2:0]   fixed_mask;
    logic         led_low;
    logic         self_pwr;
    logic         clk48;
  } hss_strap_t;

endpackage

/* File: rtl/hss_strap_latch.sv */
// strap capture on release of the internal hub reset
// assumes strap inputs are synchronous to aclk and stable at release
`timescale 1ns/1ps
`default_nettype none
`include "hss_cfg.svh"

module hss_strap_latch
  import hss_pkg::*;
#(
  parameter bit PKG_LARGE = 1'b1
)
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            aclken,
  input  wire logic            hub_run,
  input  wire logic            sel_b2,
  input  wire logic            sel_b1,
  input  wire logic            sel_b0,
  input  wire logic            fix_hi,
  input  wire logic            fix_lo,
  input  wire logic            rate_sel,
  input  wire logic            osc_external,
  output hss_pkg::hss_strap_t  straps
);

  // ****************************************
  // decode
  // ****************************************
  function automatic hss_method_t method_of(input logic [2:0] s);
    hss_method_t m;
    m = HSS_METH_DEFAULT;
    if (!s[2] && s[0])
    begin
      m = s[1] ? HSS_METH_EEPROM : HSS_METH_SMBUS;
    end
    return m;
  endfunction

  logic        run_q_ff;
  hss_strap_t  straps_ff;
  hss_strap_t  nxt_straps;
  wire logic   release_edge;
  wire logic   b2_eff;
  wire logic [2:0] sel_now;
  wire logic   strap_en_now;
  wire logic [1:0] fix_now;

  assign release_edge = hub_run & ~run_q_ff;
  assign b2_eff       = PKG_LARGE ? sel_b2 : 1'b0;
  assign sel_now      = {b2_eff, sel_b1, sel_b0};
  // strap overrides only live in the two default-with-straps codes
  assign strap_en_now = ~sel_now[2] & ~sel_now[0];
  assign fix_now      = strap_en_now ? {fix_hi, fix_lo} : 2'b00;

  always_comb
  begin
    nxt_straps            = straps_ff;
    nxt_straps.sel        = sel_now;
    nxt_straps.method     = method_of(sel_now);
    nxt_straps.strap_en   = strap_en_now;
    nxt_straps.fixed_mask = {fix_now == 2'b11, fix_now[1], |fix_now};
    nxt_straps.led_low    = fix_now[0];
    nxt_straps.self_pwr   = fix_lo;
    // 48 MHz input only exists on the large package
    nxt_straps.clk48      = PKG_LARGE & osc_external & rate_sel;
  end

  // ****************************************
  // capture, then hold until next release
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_q_ff  <= 1'b0;
      straps_ff <= '0;
    end
    else if (aclken)
    begin
      run_q_ff <= hub_run;
      if (release_edge)
      begin
        straps_ff <= nxt_straps;
      end
    end
  end

  assign straps = straps_ff;

endmodule
`default_nettype wire

/* File: sim/hss_assertions.sv */
// port-level checks for the strap sampling block
// assumes one aclk domain with synchronous active-low aresetn
`timescale 1ns/1ps
`default_nettype none
module hss_assertions
  import hss_pkg::*;
#(
  parameter bit PKG_LARGE = 1'b1
)
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire hss_pkg::hss_axi_req_t axi_req,
  input wire hss_pkg::hss_axi_rsp_t axi_rsp,
  input wire logic                  hub_reset_n,
  input wire logic                  supply_stable,
  input wire logic                  config_method_select_b2,
  input wire logic                  config_method_select_b1,
  input wire logic                  config_method_select_b0,
  input wire logic                  fixed_port_strap_hi,
  input wire logic                  led_pin_in,
  input wire logic                  hub_in_reset,
  input wire logic [2:0]            fixed_port_mask,
  input wire logic [1:0]            config_method,
  input wire logic                  self_powered
);
  // ****
  // release tracking
  // ****
  logic       run_q;
  logic [4:0] snap;
  wire        run = hub_reset_n & supply_stable;
  wire        rel = run & ~run_q;
  wire        en = ~snap[4] & ~snap[2];
  wire  [1:0] code = en ? snap[1:0] : 2'h0;
  wire  [2:0] exp_mask = {code == 2'h3, code[1], |code};
  wire  [1:0] exp_meth = (~snap[4] & snap[2]) ? {snap[3], ~snap[3]} : 2'h0;
  always_ff @(posedge aclk)
  begin
    run_q <= aresetn & run;
    if (rel)
      snap <= {PKG_LARGE & config_method_select_b2, config_method_select_b1,
               config_method_select_b0, fixed_port_strap_hi, led_pin_in};
  end
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_mask_code: assert property (rel |-> ##2 fixed_port_mask == exp_mask)
    else $error("fixed port mask wrong");
  a_method_sel: assert property (rel |-> ##2 config_method == exp_meth)
    else $error("config method wrong");
  a_self_pwr: assert property (rel |-> ##2 self_powered == snap[0])
    else $error("self power wrong");
  a_strap_hold: assert property ($past(run_q, 2) |->
    $stable({fixed_port_mask, config_method, self_powered}))
    else $error("captured straps moved");
  a_por_hold: assert property (!supply_stable |=> hub_in_reset)
    else $error("hub left reset early");
  a_release_run: assert property (rel |=> !hub_in_reset)
    else $error("hub reset not released");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready
    |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read answer late");
  a_write_done: assert property (axi_rsp.bvalid && axi_req.bready
    |=> !axi_rsp.bvalid && axi_rsp.awready && axi_rsp.wready)
    else $error("write end wrong");
  a_unmapped_rd: assert property (axi_req.arvalid && axi_rsp.arready
    && axi_req.araddr[7:2] > 6'h01 |=> axi_rsp.rresp == 2'h2 && axi_rsp.rdata == 32'h0)
    else $error("unmapped read wrong");
  c_release: cover property (rel);
  c_write: cover property (axi_rsp.bvalid && axi_req.bready);
  c_slverr: cover property (axi_rsp.rvalid && axi_rsp.rresp == 2'h2);
endmodule
bind hss_top hss_assertions #(.PKG_LARGE(PKG_LARGE)) u_chk (
  .aclk, .aresetn, .axi_req, .axi_rsp, .hub_reset_n, .supply_stable,
  .config_method_select_b2, .config_method_select_b1, .config_method_select_b0,
  .fixed_port_strap_hi, .led_pin_in, .hub_in_reset, .fixed_port_mask,
  .config_method, .self_powered
);
`default_nettype wire

/* File: sim/hss_board.sv */
// board model: strap resistors, reset pulse source, indicator pin
// assumes the bench sets the straps before each reset pulse
`timescale 1ns/1ps
`default_nettype none
module hss_board #(
  parameter int RST_CYC = 40
)
(
  input  wire logic       aclk,
  input  wire logic       rst_req,
  input  wire logic       pwr_ok,
  input  wire logic [4:0] strap,
  input  wire logic       led_pin_out,
  input  wire logic       led_pin_oe_n,
  output logic            hub_reset_n,
  output logic            config_method_select_b2,
  output logic            config_method_select_b1,
  output logic            config_method_select_b0,
  output logic            fixed_port_strap_hi,
  output logic            led_pin_in
);
  int         cnt = 0;
  logic [1:0] hold = 2'h0;
  logic       tog = 1'h0;
  wire        keep = !(hub_reset_n & pwr_ok) || (|hold);
  always_ff @(posedge aclk)
  begin
    cnt <= rst_req ? RST_CYC : (cnt > 0 ? cnt - 1 : 0);
    hold <= {hold[0], !(hub_reset_n & pwr_ok)};
    tog <= ~tog;
  end
  // 40 cycles of 25 ns keeps the pulse at the minimum width
  assign hub_reset_n = (cnt == 0);
  // after the hold time the shared pins carry other traffic
  assign {config_method_select_b2, config_method_select_b1, config_method_select_b0,
          fixed_port_strap_hi} = keep ? strap[4:1] : {4{tog}};
  assign led_pin_in = led_pin_oe_n ? strap[0] : led_pin_out;
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the strap sampling block
// assumes hss_board drives the strap pins and the hub reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hss_pkg::*;
  hss_axi_req_t axi_req;
  hss_axi_rsp_t axi_rsp;
  logic       aclk, aresetn, aclken, hub_reset_n, supply_stable, rst_req, test_enable;
  logic       config_method_select_b2, config_method_select_b1, config_method_select_b0;
  logic       fixed_port_strap_hi, ext_clock_rate_select, oscillator_external, led_pin_in;
  logic       led_pin_out, led_pin_oe_n, hub_in_reset, self_powered, clk48_mode;
  logic       continuity_out;
  logic [2:0] fixed_port_mask;
  logic [1:0] config_method;
  logic [4:0] strap;
  int         failures = 0;
  int         comparisons = 0;
  hss_top #(.PKG_LARGE(1'h1)) dut (
    .aclk, .aresetn, .aclken, .axi_req, .axi_rsp, .hub_reset_n, .supply_stable,
    .config_method_select_b2, .config_method_select_b1, .config_method_select_b0,
    .fixed_port_strap_hi, .ext_clock_rate_select, .oscillator_external, .test_enable,
    .led_pin_in, .led_pin_out, .led_pin_oe_n, .hub_in_reset, .fixed_port_mask,
    .config_method, .self_powered, .clk48_mode, .continuity_out
  );
  // small package copy: upper select bit and 48 MHz option must be absent
  logic [1:0] config_method_small;
  logic       clk48_mode_small;
  hss_top #(.PKG_LARGE(1'h0)) dut_small (
    .aclk, .aresetn, .aclken, .axi_req, .axi_rsp(), .hub_reset_n, .supply_stable,
    .config_method_select_b2, .config_method_select_b1, .config_method_select_b0,
    .fixed_port_strap_hi, .ext_clock_rate_select, .oscillator_external, .test_enable,
    .led_pin_in, .led_pin_out(), .led_pin_oe_n(), .hub_in_reset(), .fixed_port_mask(),
    .config_method(config_method_small), .self_powered(), .clk48_mode(clk48_mode_small),
    .continuity_out()
  );
  hss_board u_board (
    .aclk, .rst_req, .pwr_ok(supply_stable), .strap, .led_pin_out, .led_pin_oe_n,
    .hub_reset_n, .config_method_select_b2, .config_method_select_b1,
    .config_method_select_b0, .fixed_port_strap_hi, .led_pin_in
  );
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    n = 0;
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= s;
    axi_req.awvalid <= 1'h1;
    axi_req.wvalid <= 1'h1;
    axi_req.bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (axi_rsp.awready)
        axi_req.awvalid <= 1'h0;
      if (axi_rsp.wready)
        axi_req.wvalid <= 1'h0;
    end
    while (axi_rsp.bvalid !== 1'h1 && n < 64);
    axi_req.bready <= 1'h0;
    chk({31'h0, axi_rsp.bvalid}, 32'h0000_0001);
    chk({30'h0, axi_rsp.bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    n = 0;
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'h1;
    axi_req.rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (axi_rsp.arready)
        axi_req.arvalid <= 1'h0;
    end
    while (axi_rsp.rvalid !== 1'h1 && n < 64);
    axi_req.rready <= 1'h0;
    chk({31'h0, axi_rsp.rvalid}, 32'h0000_0001);
    chk(axi_rsp.rdata, ed);
    chk({30'h0, axi_rsp.rresp}, {30'h0, er});
  endtask
  task automatic hub_cycle();
    int n;
    n = 0;
    rst_req <= 1'h1;
    @(posedge aclk);
    rst_req <= 1'h0;
    repeat (3) @(posedge aclk);
    while (hub_in_reset !== 1'h0 && n < 100)
    begin
      @(posedge aclk);
      n++;
    end
    chk({31'h0, hub_in_reset}, 32'h0000_0000);
    repeat (4) @(posedge aclk);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs();
    rd(8'h00, 32'h0000_0000, 2'h0);
    wr(8'h00, 32'h0000_0003, 4'hf, 2'h0);
    rd(8'h00, 32'h0000_0003, 2'h0);
    // lane 0 off: control must not change
    wr(8'h00, 32'h0000_0000, 4'he, 2'h0);
    rd(8'h00, 32'h0000_0003, 2'h0);
    wr(8'h04, 32'hffff_ffff, 4'hf, 2'h0);
    wr(8'h08, 32'h0000_0001, 4'hf, 2'h2);
    rd(8'h3c, 32'h0000_0000, 2'h2);
    $display("register test done");
  endtask
  task automatic t_straps();
    logic [6:0] i;
    logic       en;
    logic       led;
    logic [1:0] code;
    logic [1:0] meth;
    logic [2:0] mask;
    for (int k = 0; k < 128; k++)
    begin
      i = 7'(k);
      @(posedge aclk);
      strap <= i[4:0];
      ext_clock_rate_select <= i[5];
      oscillator_external <= i[6];
      hub_cycle();
      wr(8'h00, {30'h0, i[6:5]}, 4'hf, 2'h0);
      repeat (2) @(posedge aclk);
      en = ~i[4] & ~i[2];
      code = en ? i[1:0] : 2'h0;
      mask = {code == 2'h3, code[1], |code};
      meth = (~i[4] & i[2]) ? {i[3], ~i[3]} : 2'h0;
      led = (i[5] & ~i[6]) ^ code[0];
      chk({29'h0, fixed_port_mask}, {29'h0, mask});
      chk({30'h0, config_method}, {30'h0, meth});
      chk({31'h0, self_powered}, {31'h0, i[0]});
      chk({31'h0, clk48_mode}, {31'h0, i[5] & i[6]});
      chk({30'h0, config_method_small}, {30'h0, i[2] ? {i[3], ~i[3]} : 2'h0});
      chk({31'h0, clk48_mode_small}, 32'h0000_0000);
      chk({30'h0, led_pin_oe_n, led_pin_out}, {31'h0, led});
      rd(8'h04, {17'h0, led, test_enable, 1'h0, en, i[5] & i[6], i[0], code[0], mask,
                 meth, i[4:2]}, 2'h0);
    end
    $display("strap test done");
  endtask
  task automatic t_power();
    @(posedge aclk);
    supply_stable <= 1'h0;
    strap <= 5'h03;
    repeat (3) @(posedge aclk);
    chk({30'h0, hub_in_reset, led_pin_oe_n}, 32'h0000_0003);
    supply_stable <= 1'h1;
    repeat (4) @(posedge aclk);
    chk({27'h0, led_pin_oe_n, led_pin_out, fixed_port_mask}, 32'h0000_000f);
    $display("power test done");
  endtask
  task automatic t_test();
    chk({31'h0, continuity_out}, 32'h0000_0000);
    test_enable <= 1'h1;
    // rate select moves after capture: status must not follow it
    ext_clock_rate_select <= 1'h0;
    rd(8'h04, 32'h0000_6fe0, 2'h0);
    chk({31'h0, continuity_out}, 32'h0000_0001);
    // clock enable low must freeze the check output
    aclken <= 1'h0;
    test_enable <= 1'h0;
    repeat (3) @(posedge aclk);
    chk({31'h0, continuity_out}, 32'h0000_0001);
    aclken <= 1'h1;
    repeat (2) @(posedge aclk);
    chk({31'h0, continuity_out}, 32'h0000_0000);
    $display("test pin test done");
  endtask
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end
  initial
  begin
    axi_req = '0;
    aresetn = 1'h0;
    aclken = 1'h1;
    supply_stable = 1'h1;
    rst_req = 1'h0;
    test_enable = 1'h0;
    ext_clock_rate_select = 1'h0;
    oscillator_external = 1'h0;
    strap = 5'h00;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_straps();
    t_power();
    t_test();
    final_report();
  end
  // about 7.4k cycles expected; hang cut at 20k
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
